// File: src/sng_params.svh
// Register offsets, field positions, reset values and sizes of the side chain gate
`ifndef SNG_PARAMS_SVH
`define SNG_PARAMS_SVH
`define SNG_ADDR_W        4
`define SNG_DATA_W        16
`define SNG_OFF_CTRL      4'h0
`define SNG_OFF_THRESH    4'h1
`define SNG_OFF_HOLD      4'h2
`define SNG_OFF_ATTACK    4'h3
`define SNG_OFF_RELEASE   4'h4
`define SNG_OFF_DECAY     4'h5
`define SNG_OFF_DELAY     4'h6
`define SNG_OFF_SHELF_G   4'h7
`define SNG_OFF_SHELF_F   4'h8
`define SNG_OFF_STATUS    4'h9
`define SNG_OFF_GAIN      4'ha
`define SNG_CTRL_GATE_IN  0
`define SNG_CTRL_INVERT   1
`define SNG_CTRL_ONESHOT  2
`define SNG_CTRL_SRC_LO   3
`define SNG_CTRL_SRC_HI   4
`define SNG_RST_CTRL      16'h0001
`define SNG_RST_THRESH    16'h0800
`define SNG_RST_HOLD      16'h0400
`define SNG_RST_ATTACK    16'h0100
`define SNG_RST_RELEASE   16'h0010
`define SNG_RST_DECAY     4'h4
`define SNG_RST_DELAY     11'h000
`define SNG_RST_SHELF_G   8'h00
`define SNG_RST_SHELF_F   7'h24
`define SNG_GAIN_FULL     16'hffff
`define SNG_DLY_AW        11
`define SNG_DLY_DEPTH     2048
`define SNG_DB_PER_STEP   6
`define SNG_SEMI_PER_OCT  12
`define SNG_SHELF_K_MAX   12
`endif

// File: src/sng_pkg.sv
// Types shared by the side chain gate
package sng_pkg;
  typedef struct packed {
    logic signed [15:0] l;
    logic signed [15:0] r;
  } sng_stereo_type;
  typedef enum logic [3:0] {
    SNG_IDLE = 4'h1,
    SNG_ATK  = 4'h2,
    SNG_HOLD = 4'h4,
    SNG_REL  = 4'h8
  } sng_state_type;
  typedef enum logic [1:0] {
    SNG_SRC_LEFT  = 2'h0,
    SNG_SRC_RIGHT = 2'h1,
    SNG_SRC_AVG   = 2'h2
  } sng_src_type;
endpackage

// File: src/sng_gate.sv
// Side chain noise gate: envelope, hold timer, ramps, delay line, low shelf, register port
`timescale 1ns/1ps
`include "sng_params.svh"
//Contract
// [R1] With invert off the gate opens when the side chain envelope exceeds the level.
// [R2] With invert on the gate closes above the level and reopens after the hold timer.
// [R3] In restartable mode the hold timer reloads every sample while above the level.
// [R4] In one-shot mode the timer starts at the rising crossing and the gate ends with it.
// [R5] In one-shot mode a new trigger needs the envelope to fall below the level first.
// [R6] The basic variant has no mode choice and always runs restartable.
// [R7] An envelope decay setting sets how fast the envelope falls, used in one-shot mode.
// [R8] The gate stays fully on for the hold time, restarted at each rising crossing.
// [R9] After a rising crossing the gain ramps to the triggered level at the attack rate.
// [R10] After the hold timer ends the gain ramps back at the release rate.
// [R11] The main path is delayed by the programmed amount, the side chain is not; with gate out the code passes the input undelayed.
// [R12] The extended variant applies a side chain low shelf, about 6 dB per doubling.
// [R13] The shelf corner is set as a semitone index.
// [R14] The side chain source is left, right or the average of both amplitudes; with a nonzero shelf gain the extended variant averages the samples instead.
// [R15] Gate in makes the gate active, gate out passes the input through ungated.
// [R16] Each delayed main sample is scaled by the current gain, updated once per sample.
module sng_gate #(
  parameter bit EXTENDED = 1'b1
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  input  wire logic [`SNG_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [`SNG_DATA_W-1:0]  reg_wdata_i,
  input  wire logic                    reg_we_i,
  input  wire logic                    reg_re_i,
  output logic      [`SNG_DATA_W-1:0]  reg_rdata_o,
  input  wire logic                    in_valid_i,
  input  sng_pkg::sng_stereo_type      in_data_i,
  output logic                         out_valid_o,
  output sng_pkg::sng_stereo_type      out_data_o
);
  // Control registers
  logic [15:0]          ctrl_q, ctrl_d;
  logic [15:0]          thresh_q, thresh_d;
  logic [15:0]          hold_q, hold_d;
  logic [15:0]          attack_q, attack_d;
  logic [15:0]          release_q, release_d;
  logic [3:0]           decay_q, decay_d;
  logic [10:0]          delay_q, delay_d;
  logic [7:0]           shelf_g_q, shelf_g_d;
  logic [6:0]           shelf_f_q, shelf_f_d;
  logic [15:0]          rdata_q, rdata_d;
  // Signal path state
  sng_pkg::sng_state_type state_q, state_d;
  logic [15:0]          gain_q, gain_d;
  logic [15:0]          timer_q, timer_d;
  logic [15:0]          env_q, env_d;
  logic                 above_q, above_d;
  logic                 armed_q, armed_d;
  logic signed [15:0]   low_q, low_d;
  logic [10:0]          wptr_q, wptr_d;
  logic                 ovalid_q, ovalid_d;
  sng_pkg::sng_stereo_type odata_q, odata_d;
  sng_pkg::sng_stereo_type dly_mem [`SNG_DLY_DEPTH];
  logic                 gate_in, invert, oneshot;
  logic [1:0]           src_sel;
  logic [15:0]          idle_lvl, trig_lvl, abs_l, abs_r, sc_amp;
  logic [16:0]          abs_sum;
  logic signed [15:0]   sc_src, sc_filt;
  logic signed [23:0]   low_sc, shelf_sum;
  logic signed [16:0]   low_diff;
  logic signed [7:0]    shelf_steps;
  logic [3:0]           shelf_k;
  logic                 rise, trig;
  sng_pkg::sng_stereo_type dly_out;
  logic [10:0]          rptr;
  logic signed [32:0]   prod_l, prod_r;
  // Step toward a target; a zero step jumps at once
  function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] tgt,
                                       input logic [15:0] step);
    logic [15:0] res;
    res = tgt;
    if (step != 16'h0000)
    begin
      if (cur < tgt)
        res = ((tgt - cur) <= step) ? tgt : cur + step;
      else if (cur > tgt)
        res = ((cur - tgt) <= step) ? tgt : cur - step;
    end
    return res;
  endfunction
  // Unsigned magnitude, so the most negative sample stays exact
  function automatic logic [15:0] mag(input logic signed [15:0] s);
    return s[15] ? 16'(-s) : 16'(s);
  endfunction
  assign gate_in = ctrl_q[`SNG_CTRL_GATE_IN];
  assign invert  = ctrl_q[`SNG_CTRL_INVERT];
  assign oneshot = EXTENDED & ctrl_q[`SNG_CTRL_ONESHOT];  // [R6]
  assign src_sel = ctrl_q[`SNG_CTRL_SRC_HI:`SNG_CTRL_SRC_LO];
  // Register port: writes land at once, reads answer one cycle later
  always_comb
  begin
    ctrl_d    = ctrl_q;
    thresh_d  = thresh_q;
    hold_d    = hold_q;
    attack_d  = attack_q;
    release_d = release_q;
    decay_d   = decay_q;
    delay_d   = delay_q;
    shelf_g_d = shelf_g_q;
    shelf_f_d = shelf_f_q;
    rdata_d   = 16'h0000;
    if (reg_we_i)
    begin
      case (reg_addr_i)
        `SNG_OFF_CTRL:    ctrl_d    = {11'h000, reg_wdata_i[4:0]};
        `SNG_OFF_THRESH:  thresh_d  = reg_wdata_i;
        `SNG_OFF_HOLD:    hold_d    = reg_wdata_i;
        `SNG_OFF_ATTACK:  attack_d  = reg_wdata_i;
        `SNG_OFF_RELEASE: release_d = reg_wdata_i;
        `SNG_OFF_DECAY:   decay_d   = reg_wdata_i[3:0];
        `SNG_OFF_DELAY:   delay_d   = reg_wdata_i[10:0];
        `SNG_OFF_SHELF_G: shelf_g_d = reg_wdata_i[7:0];
        `SNG_OFF_SHELF_F: shelf_f_d = reg_wdata_i[6:0];
        default:          ;
      endcase
    end
    if (reg_re_i)
    begin
      case (reg_addr_i)
        `SNG_OFF_CTRL:    rdata_d = ctrl_q;
        `SNG_OFF_THRESH:  rdata_d = thresh_q;
        `SNG_OFF_HOLD:    rdata_d = hold_q;
        `SNG_OFF_ATTACK:  rdata_d = attack_q;
        `SNG_OFF_RELEASE: rdata_d = release_q;
        `SNG_OFF_DECAY:   rdata_d = {12'h000, decay_q};
        `SNG_OFF_DELAY:   rdata_d = {5'h00, delay_q};
        `SNG_OFF_SHELF_G: rdata_d = {8'h00, shelf_g_q};
        `SNG_OFF_SHELF_F: rdata_d = {9'h000, shelf_f_q};
        `SNG_OFF_STATUS:  rdata_d = {10'h000, armed_q, above_q, state_q};
        `SNG_OFF_GAIN:    rdata_d = gain_q;
        default:          rdata_d = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q    <= `SNG_RST_CTRL;
      thresh_q  <= `SNG_RST_THRESH;
      hold_q    <= `SNG_RST_HOLD;
      attack_q  <= `SNG_RST_ATTACK;
      release_q <= `SNG_RST_RELEASE;
      decay_q   <= `SNG_RST_DECAY;
      delay_q   <= `SNG_RST_DELAY;
      shelf_g_q <= `SNG_RST_SHELF_G;
      shelf_f_q <= `SNG_RST_SHELF_F;
      rdata_q   <= 16'h0000;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      thresh_q  <= thresh_d;
      hold_q    <= hold_d;
      attack_q  <= attack_d;
      release_q <= release_d;
      decay_q   <= decay_d;
      delay_q   <= delay_d;
      shelf_g_q <= shelf_g_d;
      shelf_f_q <= shelf_f_d;
      rdata_q   <= rdata_d;
    end
  end
  assign reg_rdata_o = rdata_q;
  // Side chain source and low shelf; shifts stand in for multipliers to keep area low
  always_comb
  begin
    abs_l   = mag(in_data_i.l);
    abs_r   = mag(in_data_i.r);
    abs_sum = {1'b0, abs_l} + {1'b0, abs_r};
    case (src_sel)
      sng_pkg::SNG_SRC_LEFT:  sc_src = in_data_i.l;  // [R14]
      sng_pkg::SNG_SRC_RIGHT: sc_src = in_data_i.r;  // [R14]
      default:                sc_src = (in_data_i.l >>> 1) + (in_data_i.r >>> 1);  // [R14]
    endcase
    shelf_k = 4'(`SNG_SHELF_K_MAX) - 4'(shelf_f_q / 7'(`SNG_SEMI_PER_OCT));  // [R13]
    low_diff    = 17'(sc_src) - 17'(low_q);
    low_d       = low_q + 16'(low_diff >>> shelf_k);
    shelf_steps = $signed(shelf_g_q) / 8'sd6;  // [R12]
    if (shelf_steps > 8'sd7)
      shelf_steps = 8'sd7;
    if (shelf_steps < -8'sd7)
      shelf_steps = -8'sd7;
    if (shelf_steps >= 0)
      low_sc = 24'(low_q) <<< shelf_steps[2:0];  // [R12]
    else
      low_sc = 24'(low_q) >>> 3'(-shelf_steps);  // [R12]
    shelf_sum = 24'(sc_src) - 24'(low_q) + low_sc;
    if (shelf_sum > 24'sd32767)
      sc_filt = 16'sh7fff;
    else if (shelf_sum < -24'sd32768)
      sc_filt = -16'sh8000;
    else
      sc_filt = shelf_sum[15:0];
    if (!EXTENDED)
      sc_filt = sc_src;
    // Averaged source uses the mean of both amplitudes with zero shelf gain or in the basic variant, else the amplitude of the mean sample
    if (src_sel == sng_pkg::SNG_SRC_AVG && (!EXTENDED || shelf_g_q == 8'h00))
      sc_amp = abs_sum[16:1];  // [R14]
    else
      sc_amp = mag(sc_filt);
  end
  // Envelope, crossing detect, hold timer and gate state
  always_comb
  begin
    state_d  = state_q;
    gain_d   = gain_q;
    timer_d  = timer_q;
    env_d    = env_q;
    above_d  = above_q;
    armed_d  = armed_q;
    idle_lvl = invert ? `SNG_GAIN_FULL : 16'h0000;  // [R1] [R2]
    trig_lvl = invert ? 16'h0000 : `SNG_GAIN_FULL;  // [R1] [R2]
    rise     = 1'b0;
    trig     = 1'b0;
    if (in_valid_i)
    begin
      if (!oneshot || sc_amp > env_q)
        env_d = sc_amp;
      else
        env_d = env_q - (env_q >> decay_q);  // [R7]
      above_d = env_d > thresh_q;  // [R1]
      rise    = above_d & ~above_q;
      trig    = rise & (armed_q | ~oneshot);  // [R5]
      if (!oneshot)
        armed_d = 1'b1;
      else if (trig)
        armed_d = 1'b0;  // [R5]
      else if (!above_d)
        armed_d = 1'b1;  // [R5]
      if (trig)
        timer_d = hold_q;  // [R8] [R4]
      else if (!oneshot && above_d && state_q != sng_pkg::SNG_IDLE)
        timer_d = hold_q;  // [R3]
      else if (timer_q != 16'h0000)
        timer_d = timer_q - 16'h0001;
      case (state_q)
        sng_pkg::SNG_IDLE:
        begin
          gain_d = idle_lvl;
          if (trig)
            state_d = sng_pkg::SNG_ATK;
        end
        sng_pkg::SNG_ATK:
        begin
          gain_d = ramp(gain_q, trig_lvl, attack_q);  // [R9]
          if (gain_d == trig_lvl)
            state_d = sng_pkg::SNG_HOLD;
        end
        sng_pkg::SNG_HOLD:
        begin
          gain_d = trig_lvl;  // [R8]
          if (timer_d == 16'h0000)
            state_d = sng_pkg::SNG_REL;  // [R4] [R2]
        end
        sng_pkg::SNG_REL:
        begin
          gain_d = ramp(gain_q, idle_lvl, release_q);  // [R10]
          if (trig || (!oneshot && above_d))
            state_d = sng_pkg::SNG_ATK;  // [R3]
          else if (gain_d == idle_lvl)
            state_d = sng_pkg::SNG_IDLE;
        end
        default:
        begin
          state_d = sng_pkg::SNG_IDLE;
          gain_d  = idle_lvl;
        end
      endcase
    end
  end
  // Main path: delay read, gain multiply, bypass
  always_comb
  begin
    wptr_d   = wptr_q;
    ovalid_d = in_valid_i;
    odata_d  = odata_q;
    rptr     = wptr_q - delay_q;  // [R11]
    dly_out  = (delay_q == 11'h000) ? in_data_i : dly_mem[rptr];  // [R11]
    prod_l   = 33'(dly_out.l) * $signed({17'h00000, gain_d});  // [R16]
    prod_r   = 33'(dly_out.r) * $signed({17'h00000, gain_d});  // [R16]
    if (in_valid_i)
    begin
      wptr_d = wptr_q + 11'h001;
      if (gate_in)
      begin
        odata_d.l = prod_l[31:16];  // [R16] [R15]
        odata_d.r = prod_r[31:16];  // [R16] [R15]
      end
      else
        odata_d = in_data_i;  // [R15]
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q  <= sng_pkg::SNG_IDLE;
      gain_q   <= 16'h0000;
      timer_q  <= 16'h0000;
      env_q    <= 16'h0000;
      above_q  <= 1'b0;
      armed_q  <= 1'b1;
      low_q    <= 16'sh0000;
      wptr_q   <= 11'h000;
      ovalid_q <= 1'b0;
      odata_q  <= '0;
    end
    else
    begin
      state_q  <= state_d;
      gain_q   <= gain_d;
      timer_q  <= timer_d;
      env_q    <= env_d;
      above_q  <= above_d;
      armed_q  <= armed_d;
      low_q    <= in_valid_i ? low_d : low_q;
      wptr_q   <= wptr_d;
      ovalid_q <= ovalid_d;
      odata_q  <= odata_d;
    end
  end
  // Delay storage has no reset; stale samples leave it within one window
  always_ff @(posedge clk_sys_i)
  begin
    if (in_valid_i)
      dly_mem[wptr_q] <= in_data_i;  // [R11]
  end
  assign out_valid_o = ovalid_q;
  assign out_data_o  = odata_q;
endmodule // sng_gate

// File: sim/sng_src_model.sv
// Upstream stereo sample source feeding the gate
`timescale 1ns/1ps
module sng_src_model (
  input  wire logic               clk_sys_i,
  output logic                    in_valid_o,
  output sng_pkg::sng_stereo_type in_data_o
);
  initial
  begin
    in_valid_o = 1'b0;
    in_data_o  = '0;
  end
  // One sample per call; data lines scrambled once the strobe drops
  task automatic send(input logic [15:0] l, input logic [15:0] r);
    @(posedge clk_sys_i);
    in_valid_o <= 1'b1;
    in_data_o  <= {l, r};
    @(posedge clk_sys_i);
    in_valid_o <= 1'b0;
    in_data_o  <= ~{l, r};
  endtask
endmodule // sng_src_model

// File: sim/sng_gate_monitor.sv
// Port-level assertions for the side chain gate
`timescale 1ns/1ps
`include "sng_params.svh"
module sng_gate_monitor (
  input wire logic                   clk_sys_i,
  input wire logic                   resetn_i,
  input wire logic [`SNG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`SNG_DATA_W-1:0] reg_wdata_i,
  input wire logic                   reg_we_i,
  input wire logic                   reg_re_i,
  input wire logic [`SNG_DATA_W-1:0] reg_rdata_o,
  input wire logic                   in_valid_i,
  input sng_pkg::sng_stereo_type     in_data_i,
  input wire logic                   out_valid_o,
  input sng_pkg::sng_stereo_type     out_data_o
);
  logic [4:0]  ctrl_q, ctrl_d;
  logic [15:0] thr_q, thr_d;
  logic [10:0] dly_q, dly_d;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  function automatic logic [16:0] mag(input logic [15:0] v);
    return v[15] ? 17'h00000 - {v[15], v} : {1'b0, v};
  endfunction
  // Shadow of the settings the checks lean on
  always_comb
  begin
    ctrl_d = ctrl_q;
    thr_d  = thr_q;
    dly_d  = dly_q;
    if (reg_we_i && reg_addr_i == `SNG_OFF_CTRL)
      ctrl_d = reg_wdata_i[4:0];
    if (reg_we_i && reg_addr_i == `SNG_OFF_THRESH)
      thr_d = reg_wdata_i;
    if (reg_we_i && reg_addr_i == `SNG_OFF_DELAY)
      dly_d = reg_wdata_i[10:0];
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_q <= 5'(`SNG_RST_CTRL);
      thr_q  <= `SNG_RST_THRESH;
      dly_q  <= `SNG_RST_DELAY;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      thr_q  <= thr_d;
      dly_q  <= dly_d;
    end
  end
  a_out_valid_follows: assert property (in_valid_i |=> out_valid_o)
    else $error("sample without output strobe");
  a_no_extra_valid: assert property (!in_valid_i |=> !out_valid_o)
    else $error("output strobe without sample");
  a_out_data_held: assert property (!in_valid_i |=> $stable(out_data_o))
    else $error("output changed between samples");
  a_bypass_pass: assert property (in_valid_i && !ctrl_q[0] && dly_q == 11'h000
    |=> out_data_o == $past(in_data_i)) else $error("bypass altered sample");
  a_gain_bounded: assert property (in_valid_i && ctrl_q[0] && dly_q == 11'h000
    |=> mag(out_data_o.l) <= mag($past(in_data_i.l))
    && mag(out_data_o.r) <= mag($past(in_data_i.r))) else $error("gated output grew");
  a_ctrl_readback: assert property (reg_re_i && reg_addr_i == `SNG_OFF_CTRL
    |=> reg_rdata_o == {11'h000, ctrl_q}) else $error("control readback wrong");
  a_thresh_readback: assert property (reg_re_i && reg_addr_i == `SNG_OFF_THRESH
    |=> reg_rdata_o == thr_q) else $error("level readback wrong");
  a_delay_readback: assert property (reg_re_i && reg_addr_i == `SNG_OFF_DELAY
    |=> reg_rdata_o == {5'h00, dly_q}) else $error("delay readback wrong");
  a_status_shape: assert property (reg_re_i && reg_addr_i == `SNG_OFF_STATUS
    |=> reg_rdata_o[15:6] == 10'h000 && $onehot(reg_rdata_o[3:0]))
    else $error("status malformed");
endmodule // sng_gate_monitor

// File: sim/sng_gate_test.sv
// Self-checking bench for the side chain gate
`timescale 1ns/1ps
`include "sng_params.svh"
module sng_gate_test;
  logic                    clk_sys_i   = 1'b0;
  logic                    resetn_i    = 1'b0;
  logic [`SNG_ADDR_W-1:0]  reg_addr_i  = 4'h0;
  logic [`SNG_DATA_W-1:0]  reg_wdata_i = 16'h0000;
  logic                    reg_we_i    = 1'b0;
  logic                    reg_re_i    = 1'b0;
  logic [`SNG_DATA_W-1:0]  reg_rdata_o;
  logic                    in_valid_i;
  logic                    out_valid_o;
  sng_pkg::sng_stereo_type in_data_i;
  sng_pkg::sng_stereo_type out_data_o;
  int                      n_fail  = 0;
  int                      n_tests = 0;
  int                      cyc     = 0;
  logic [15:0]             rst_tab [12] = '{16'h0001, 16'h0800, 16'h0400, 16'h0100,
    16'h0010, 16'h0004, 16'h0000, 16'h0000, 16'h0024, 16'h0021, 16'h0000, 16'h0000};
  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;
  sng_gate dut (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .in_valid_i, .in_data_i, .out_valid_o, .out_data_o);
  sng_src_model src (.clk_sys_i, .in_valid_o(in_valid_i), .in_data_o(in_data_i));
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_we_i <= 1'b0;
  endtask
  // Read data is only there in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic quiet(input int n);
    repeat (n) src.send(16'h0000, 16'h0000);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 12; i++)
      rd_chk(i[3:0], rst_tab[i]);
    wr(`SNG_OFF_STATUS, 16'hffff);
    rd_chk(`SNG_OFF_STATUS, 16'h0021);
    wr(`SNG_OFF_CTRL, 16'hffff);
    rd_chk(`SNG_OFF_CTRL, 16'h001f);
  endtask
  task automatic t_bypass();
    wr(`SNG_OFF_CTRL, 16'h0000);
    src.send(16'h4000, 16'hc000);
    #1 chk(out_data_o.l, 16'h4000);
    chk(out_data_o.r, 16'hc000);
  endtask
  // Step of full scale makes the ramps jump in one sample
  task automatic t_open();
    wr(`SNG_OFF_CTRL, 16'h0001);
    wr(`SNG_OFF_ATTACK, 16'hffff);
    wr(`SNG_OFF_RELEASE, 16'hffff);
    wr(`SNG_OFF_HOLD, 16'h0004);
    quiet(1);
    #1 chk(out_data_o.l, 16'h0000);
    src.send(16'h4000, 16'h4000);
    #1 chk(out_data_o.l, 16'h3fff);
    repeat (10) src.send(16'h4000, 16'h4000);
    quiet(2);
    rd_chk(`SNG_OFF_GAIN, 16'hffff);
    quiet(8);
    rd_chk(`SNG_OFF_GAIN, 16'h0000);
  endtask
  // Slow decay holds the envelope high; a fast one lets it drop and re-arm
  task automatic t_oneshot();
    wr(`SNG_OFF_DECAY, 16'h000f);
    wr(`SNG_OFF_CTRL, 16'h0005);
    repeat (12) src.send(16'h4000, 16'h4000);
    rd_chk(`SNG_OFF_GAIN, 16'h0000);
    rd_chk(`SNG_OFF_STATUS, 16'h0011);
    wr(`SNG_OFF_DECAY, 16'h0000);
    quiet(3);
    repeat (2) src.send(16'h4000, 16'h4000);
    rd_chk(`SNG_OFF_GAIN, 16'hffff);
    wr(`SNG_OFF_CTRL, 16'h0001);
    quiet(10);
  endtask
  // A trigger sample leaves idle; the ramp shows on the next one
  task automatic t_source();
    wr(`SNG_OFF_CTRL, 16'h0009);
    src.send(16'h4000, 16'h0000);
    rd_chk(`SNG_OFF_GAIN, 16'h0000);
    wr(`SNG_OFF_CTRL, 16'h0011);
    src.send(16'h0c00, 16'h0000);
    rd_chk(`SNG_OFF_GAIN, 16'h0000);
    repeat (2) src.send(16'h0c00, 16'h0c00);
    rd_chk(`SNG_OFF_GAIN, 16'hffff);
    quiet(10);
  endtask
  // Low level keeps the gate open; full gain costs one count per sample
  task automatic t_delay();
    wr(`SNG_OFF_CTRL, 16'h0001);
    wr(`SNG_OFF_THRESH, 16'h0010);
    wr(`SNG_OFF_DELAY, 16'h0003);
    for (int i = 1; i < 7; i++)
    begin
      src.send(16'(i * 256), 16'h0000);
      if (i > 3)
        #1 chk(out_data_o.l, 16'((i - 3) * 256 - 1));
    end
    wr(`SNG_OFF_DELAY, 16'h0000);
    wr(`SNG_OFF_THRESH, 16'h0800);
    quiet(10);
  endtask
  // Inverted: loud side chain shuts, expiry reopens
  task automatic t_invert();
    wr(`SNG_OFF_CTRL, 16'h0003);
    repeat (2) src.send(16'h4000, 16'h4000);
    rd_chk(`SNG_OFF_GAIN, 16'h0000);
    quiet(10);
    rd_chk(`SNG_OFF_GAIN, 16'hffff);
  endtask
  // Bass boost with a high corner lifts a steady low side chain over the level
  task automatic t_shelf();
    wr(`SNG_OFF_CTRL, 16'h0001);
    repeat (2) src.send(16'h0400, 16'h0000);
    rd_chk(`SNG_OFF_GAIN, 16'h0000);
    wr(`SNG_OFF_SHELF_F, 16'h007f);
    wr(`SNG_OFF_SHELF_G, 16'h000c);
    repeat (8) src.send(16'h0400, 16'h0000);
    rd_chk(`SNG_OFF_GAIN, 16'hffff);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_regs();
    t_bypass();
    t_open();
    t_oneshot();
    t_source();
    t_delay();
    t_invert();
    t_shelf();
    tally_and_finish();
  end
endmodule // sng_gate_test
bind sng_gate sng_gate_monitor mon (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .in_valid_i, .in_data_i, .out_valid_o, .out_data_o);
